// ### include/icu_pkg.sv
// Shared constants of the interrupt controller: register map, field positions, modes.
// Assumes one system clock and a plain register port with 8-bit byte addresses.
package icu_pkg;

  // ==========================================================================
  // Register port
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PRIO_W = 4;
  localparam int FILT_LEN_DEF = 3;

  localparam logic [ADDR_W-1:0] OFS_PEND = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CPU_EN = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DTC_SEL = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_SW_TRIG = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_FAST_SEL = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_NMI_CFG = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_NMI_STAT = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_PWR_MODE = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_PIN_CFG = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_PRIO = 8'h40;
  localparam int WORD_SHIFT = 2;

  // ==========================================================================
  // Field layout
  localparam int SW_TRIG_BIT = 0;
  localparam int FAST_VALID_BIT = 7;
  localparam int NMI_CFG_RISE_BIT = 0;
  localparam int NMI_CFG_FILT_BIT = 1;
  localparam int PIN_CFG_MODE_LSB = 0;
  localparam int PIN_CFG_FILT_BIT = 2;
  localparam int PIN_CFG_W = 3;

  // Non-maskable status bits
  localparam int NMI_W = 6;
  localparam int NMI_PIN = 0;
  localparam int NMI_OSC = 1;
  localparam int NMI_WDT_UF = 2;
  localparam int NMI_WDT_REF = 3;
  localparam int NMI_VMON1 = 4;
  localparam int NMI_VMON2 = 5;

  // Pin detection modes
  localparam logic [1:0] DET_LOW = 2'h0;
  localparam logic [1:0] DET_FALL = 2'h1;
  localparam logic [1:0] DET_RISE = 2'h2;
  localparam logic [1:0] DET_BOTH = 2'h3;

  // Power modes
  localparam logic [1:0] PWR_RUN = 2'h0;
  localparam logic [1:0] PWR_SLEEP = 2'h1;
  localparam logic [1:0] PWR_DEEP = 2'h2;
  localparam logic [1:0] PWR_STBY = 2'h3;

endpackage : icu_pkg

// ### include/icu_arb_if.sv
// Request vector, levels and winner between the controller and its arbiter.
// Assumes the arbiter is purely combinational.
`timescale 1ns/1ps
`default_nettype none
interface icu_arb_if #(
  parameter int N = 19,
  parameter int PW = 4
);
  logic [N-1:0] req;
  logic [N-1:0][PW-1:0] lvl;
  logic valid;
  logic [$clog2(N)-1:0] id;
  logic [PW-1:0] level;

  modport arb (input req, input lvl, output valid, output id, output level);
  modport user (output req, output lvl, input valid, input id, input level);
endinterface : icu_arb_if
`default_nettype wire

// ### core/icu_arb.sv
// Priority arbiter: highest nonzero level wins, lowest index breaks ties.
// Assumes requests are already gated by enable; level zero means never served.
`timescale 1ns/1ps
`default_nettype none
module icu_arb #(
  parameter int N = 19,
  parameter int PW = 4
) (
  icu_arb_if.arb a
);
  localparam int IDW = $clog2(N);

  always_comb begin
    a.valid = 1'b0;
    a.id = '0;
    a.level = '0;
    for (int i = 0; i < N; i++) begin
      if (a.req[i] && (a.lvl[i] != '0) && (!a.valid || (a.lvl[i] > a.level))) begin // R07
        a.valid = 1'b1;
        a.id = IDW'(i);
        a.level = a.lvl[i];
      end
    end
  end
endmodule : icu_arb
`default_nettype wire

// ### core/icu_pin_det.sv
// Noise filter and condition detector for one request pin.
// Assumes the pin is already synchronous to the clock; idle level is high.
`timescale 1ns/1ps
`default_nettype none
module icu_pin_det
  import icu_pkg::*;
#(
  parameter int FILT_LEN = FILT_LEN_DEF
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic pin_i,
  input wire logic filt_en_i,
  input wire logic [1:0] mode_i,
  output logic det_o,
  output logic lvl_o
);
  localparam int CW = $clog2(FILT_LEN + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic filt;
    logic prev;
    logic det;
  } icu_det_s;

  icu_det_s s_r;
  icu_det_s s_nxt;
  logic samp;

  always_comb begin
    s_nxt = s_r;
    // Filter: a new level is taken only after it holds FILT_LEN samples
    if (pin_i == s_r.filt) begin // R04
      s_nxt.cnt = '0;
    end else if (s_r.cnt == CW'(FILT_LEN - 1)) begin
      s_nxt.cnt = '0;
      s_nxt.filt = pin_i;
    end else begin
      s_nxt.cnt = s_r.cnt + CW'(1);
    end
    samp = filt_en_i ? s_r.filt : pin_i; // R04
    s_nxt.prev = samp;
    unique case (mode_i) // R03
      DET_LOW: s_nxt.det = ~samp;
      DET_FALL: s_nxt.det = ~samp & s_r.prev;
      DET_RISE: s_nxt.det = samp & ~s_r.prev;
      DET_BOTH: s_nxt.det = samp ^ s_r.prev;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      s_r <= '{cnt: '0, filt: 1'b1, prev: 1'b1, det: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign det_o = s_r.det;
  assign lvl_o = (mode_i == DET_LOW);
endmodule : icu_pin_det
`default_nettype wire

// ### core/icu_top.sv
// Interrupt controller top: sources, pending latches, priority, fast select,
// transfer-controller routing, non-maskable sources and wake-up.
// Assumes all inputs synchronous to ref_clk_i; register port never waits.
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Function
// R01: Peripheral inputs use edge or level detection fixed per source at build time.
// R02: External request pins are a parameterised count, eight or six, numbered from zero.
// R03: Each pin detects low level, falling, rising or both edges, chosen per pin.
// R04: Each pin has an optional digital noise filter ahead of detection.
// R05: Writing the trigger register raises the single software source.
// R06: With an event link unit, its two linked events raise two dedicated sources.
// R07: Each maskable source has a writable priority level used for arbitration.
// R08: Only one source at a time can be marked for fast handling.
// R09: Sources can trigger the transfer controller instead of or besides the CPU.
// R10: Non-maskable pin detects falling or rising edge, with optional noise filter.
// R11: Oscillator stop report raises a non-maskable request.
// R12: Watchdog underflow or refresh error raises a non-maskable request.
// R13: Voltage monitors one and two each raise their own non-maskable request.
// R14: Sleep wakes on any source; standby wakes only on non-maskable or pins.
// R15: Non-maskable requests bypass priority and enable, served before maskable ones.
// R16: Edge requests stay pending until accepted by CPU or transfer unit, or cleared.
module icu_top
  import icu_pkg::*;
#(
  parameter int NUM_PERIPH = 8,
  parameter logic [NUM_PERIPH-1:0] PERIPH_EDGE = '1,
  parameter int NUM_PINS = 8,
  parameter bit HAS_EVENT_LINK = 1'b1,
  parameter int FILT_LEN = FILT_LEN_DEF
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  input wire logic [NUM_PERIPH-1:0] periph_req_i,
  input wire logic [NUM_PINS-1:0] ext_req_pin_i,
  input wire logic event_link_irq_a_i,
  input wire logic event_link_irq_b_i,
  input wire logic nmi_pin_i,
  input wire logic osc_stop_i,
  input wire logic wdt_underflow_i,
  input wire logic wdt_refresh_err_i,
  input wire logic vmon_one_i,
  input wire logic vmon_two_i,
  output logic irq_req_o,
  output logic [$clog2(NUM_PERIPH + NUM_PINS + 3)-1:0] irq_id_o,
  output logic [PRIO_W-1:0] irq_lvl_o,
  output logic irq_fast_o,
  input wire logic cpu_ack_i,
  output logic dtc_req_o,
  output logic [$clog2(NUM_PERIPH + NUM_PINS + 3)-1:0] dtc_id_o,
  input wire logic dtc_ack_i,
  output logic nmi_o,
  output logic wake_o
);
  // ==========================================================================
  // Source map
  localparam int N = NUM_PERIPH + NUM_PINS + 3;
  localparam int IDW = $clog2(N);
  localparam int SRC_PIN0 = NUM_PERIPH;
  localparam int SRC_SW = NUM_PERIPH + NUM_PINS;
  localparam int SRC_ELA = SRC_SW + 1;
  localparam int SRC_ELB = SRC_SW + 2;

  typedef struct packed {
    logic [N-1:0] pend;
    logic [N-1:0] cpu_en;
    logic [N-1:0] dtc_sel;
    logic [N-1:0][PRIO_W-1:0] prio;
    logic [NUM_PINS-1:0][PIN_CFG_W-1:0] pin_cfg;
    logic fast_v;
    logic [IDW-1:0] fast_id;
    logic [1:0] nmi_cfg;
    logic [NMI_W-1:0] nmi_stat;
    logic [NMI_W-1:1] nmi_prev;
    logic [1:0] pwr;
    logic sw_pulse;
    logic [DATA_W-1:0] rdata;
    logic irq_req;
    logic [IDW-1:0] irq_id;
    logic [PRIO_W-1:0] irq_lvl;
    logic irq_fast;
    logic dtc_req;
    logic [IDW-1:0] dtc_id;
    logic nmi;
    logic wake;
  } icu_top_s;

  icu_top_s s_r;
  icu_top_s s_nxt;

  // ==========================================================================
  // Address decode helpers
  function automatic logic blk_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base, input int cnt);
    logic [ADDR_W-1:0] d;
    d = a - base;
    return (a >= base) && (a[WORD_SHIFT-1:0] == '0) && (int'(d >> WORD_SHIFT) < cnt);
  endfunction : blk_hit

  function automatic int blk_idx(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base);
    logic [ADDR_W-1:0] d;
    d = a - base;
    return int'(d >> WORD_SHIFT);
  endfunction : blk_idx

  // ==========================================================================
  // Pin detectors
  logic [NUM_PINS-1:0] pin_det;
  logic [NUM_PINS-1:0] pin_lvl;
  logic nmi_pin_det;

  generate
    for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin // R02
      icu_pin_det #(.FILT_LEN(FILT_LEN)) u_det (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .pin_i(ext_req_pin_i[g]),
        .filt_en_i(s_r.pin_cfg[g][PIN_CFG_FILT_BIT]),
        .mode_i(s_r.pin_cfg[g][PIN_CFG_MODE_LSB +: 2]),
        .det_o(pin_det[g]),
        .lvl_o(pin_lvl[g])
      );
    end
  endgenerate

  icu_pin_det #(.FILT_LEN(FILT_LEN)) u_nmi_det (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .pin_i(nmi_pin_i),
    .filt_en_i(s_r.nmi_cfg[NMI_CFG_FILT_BIT]), // R10
    .mode_i(s_r.nmi_cfg[NMI_CFG_RISE_BIT] ? DET_RISE : DET_FALL), // R10
    .det_o(nmi_pin_det),
    .lvl_o()
  );

  // ==========================================================================
  // Arbiters for CPU and transfer controller
  icu_arb_if #(.N(N), .PW(PRIO_W)) cpu_if ();
  icu_arb_if #(.N(N), .PW(PRIO_W)) dtc_if ();

  icu_arb #(.N(N), .PW(PRIO_W)) u_cpu_arb (.a(cpu_if));
  icu_arb #(.N(N), .PW(PRIO_W)) u_dtc_arb (.a(dtc_if));

  // Arbitrate on next pending so an accepted source drops out at once
  assign cpu_if.req = s_nxt.pend & s_nxt.cpu_en;
  assign cpu_if.lvl = s_r.prio; // R07
  assign dtc_if.req = s_nxt.pend & s_nxt.dtc_sel; // R09
  assign dtc_if.lvl = s_r.prio;

  // ==========================================================================
  // Next state
  logic [N-1:0] evt;
  logic [N-1:0] is_lvl;
  logic [N-1:0] clr;
  logic [NMI_W-1:0] nmi_in;
  logic [NMI_W-1:0] nmi_set;
  logic wr_hit_pin;
  logic wr_hit_prio;

  always_comb begin
    s_nxt = s_r;
    evt = '0;
    is_lvl = '0;
    clr = '0;
    wr_hit_pin = wr_i && blk_hit(addr_i, OFS_PIN_CFG, NUM_PINS);
    wr_hit_prio = wr_i && blk_hit(addr_i, OFS_PRIO, N);

    // Raw source events
    evt[NUM_PERIPH-1:0] = periph_req_i;
    is_lvl[NUM_PERIPH-1:0] = ~PERIPH_EDGE; // R01
    evt[SRC_PIN0 +: NUM_PINS] = pin_det;
    is_lvl[SRC_PIN0 +: NUM_PINS] = pin_lvl; // R03
    evt[SRC_SW] = s_r.sw_pulse; // R05
    evt[SRC_ELA] = HAS_EVENT_LINK & event_link_irq_a_i; // R06
    evt[SRC_ELB] = HAS_EVENT_LINK & event_link_irq_b_i; // R06

    // Clears: software write-one, CPU accept, transfer accept
    if (wr_i && (addr_i == OFS_PEND)) begin
      clr = wdata_i[N-1:0];
    end
    if (cpu_ack_i && s_r.irq_req) begin
      clr[s_r.irq_id] = 1'b1; // R16
    end
    if (dtc_ack_i && s_r.dtc_req) begin
      clr[s_r.dtc_id] = 1'b1; // R16
    end
    // Level sources follow input; edge sources latch and a new event beats a clear
    s_nxt.pend = (is_lvl & evt) | (~is_lvl & ((s_r.pend & ~clr) | evt)); // R16

    // Non-maskable sources: pin through its edge detector, the others taken on their rising edge
    nmi_in = {vmon_two_i, vmon_one_i, wdt_refresh_err_i, wdt_underflow_i, osc_stop_i, 1'b0};
    nmi_set = '0;
    nmi_set[NMI_PIN] = nmi_pin_det; // R10
    nmi_set[NMI_W-1:1] = nmi_in[NMI_W-1:1] & ~s_r.nmi_prev; // R11 R12 R13
    s_nxt.nmi_prev = nmi_in[NMI_W-1:1];
    s_nxt.nmi_stat = s_r.nmi_stat;
    if (wr_i && (addr_i == OFS_NMI_STAT)) begin
      s_nxt.nmi_stat = s_r.nmi_stat & ~wdata_i[NMI_W-1:0];
    end
    s_nxt.nmi_stat = s_nxt.nmi_stat | nmi_set;

    // Register writes
    s_nxt.sw_pulse = wr_i && (addr_i == OFS_SW_TRIG) && wdata_i[SW_TRIG_BIT]; // R05
    if (wr_i) begin
      unique case (addr_i)
        OFS_CPU_EN: s_nxt.cpu_en = wdata_i[N-1:0];
        OFS_DTC_SEL: s_nxt.dtc_sel = wdata_i[N-1:0]; // R09
        OFS_FAST_SEL: begin
          // One id field holds the choice, so a second source cannot be marked
          s_nxt.fast_v = wdata_i[FAST_VALID_BIT]; // R08
          s_nxt.fast_id = wdata_i[IDW-1:0]; // R08
        end
        OFS_NMI_CFG: s_nxt.nmi_cfg = wdata_i[1:0]; // R10
        OFS_PWR_MODE: s_nxt.pwr = wdata_i[1:0];
        default: begin
        end
      endcase
    end
    if (wr_hit_pin) begin
      s_nxt.pin_cfg[blk_idx(addr_i, OFS_PIN_CFG)] = wdata_i[PIN_CFG_W-1:0]; // R03 R04
    end
    if (wr_hit_prio) begin
      s_nxt.prio[blk_idx(addr_i, OFS_PRIO)] = wdata_i[PRIO_W-1:0]; // R07
    end

    // Register reads, data in the following cycle
    s_nxt.rdata = '0;
    if (rd_i) begin
      unique case (addr_i)
        OFS_PEND: s_nxt.rdata[N-1:0] = s_r.pend;
        OFS_CPU_EN: s_nxt.rdata[N-1:0] = s_r.cpu_en;
        OFS_DTC_SEL: s_nxt.rdata[N-1:0] = s_r.dtc_sel;
        OFS_FAST_SEL: begin
          s_nxt.rdata[FAST_VALID_BIT] = s_r.fast_v;
          s_nxt.rdata[IDW-1:0] = s_r.fast_id;
        end
        OFS_NMI_CFG: s_nxt.rdata[1:0] = s_r.nmi_cfg;
        OFS_NMI_STAT: s_nxt.rdata[NMI_W-1:0] = s_r.nmi_stat;
        OFS_PWR_MODE: s_nxt.rdata[1:0] = s_r.pwr;
        default: begin
          if (blk_hit(addr_i, OFS_PIN_CFG, NUM_PINS)) begin
            s_nxt.rdata[PIN_CFG_W-1:0] = s_r.pin_cfg[blk_idx(addr_i, OFS_PIN_CFG)];
          end else if (blk_hit(addr_i, OFS_PRIO, N)) begin
            s_nxt.rdata[PRIO_W-1:0] = s_r.prio[blk_idx(addr_i, OFS_PRIO)];
          end
        end
      endcase
    end

    // Outputs to CPU and transfer controller
    s_nxt.nmi = |s_nxt.nmi_stat; // R15
    // CPU requests wait while any non-maskable one is outstanding; transfer requests do not
    s_nxt.irq_req = cpu_if.valid && !s_nxt.nmi; // R15
    s_nxt.irq_id = cpu_if.id;
    s_nxt.irq_lvl = cpu_if.level;
    s_nxt.irq_fast = cpu_if.valid && s_nxt.fast_v && (cpu_if.id == s_nxt.fast_id); // R08
    s_nxt.dtc_req = dtc_if.valid; // R09
    s_nxt.dtc_id = dtc_if.id;

    // Wake-up from low power modes
    unique case (s_r.pwr)
      PWR_RUN: s_nxt.wake = 1'b0;
      PWR_SLEEP, PWR_DEEP: s_nxt.wake = s_nxt.nmi || |(s_nxt.pend & (s_nxt.cpu_en | s_nxt.dtc_sel)); // R14
      PWR_STBY: s_nxt.wake = s_nxt.nmi || |s_nxt.pend[SRC_PIN0 +: NUM_PINS]; // R14
    endcase
  end

  // ==========================================================================
  // State register
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata_o = s_r.rdata;
  assign irq_req_o = s_r.irq_req;
  assign irq_id_o = s_r.irq_id;
  assign irq_lvl_o = s_r.irq_lvl;
  assign irq_fast_o = s_r.irq_fast;
  assign dtc_req_o = s_r.dtc_req;
  assign dtc_id_o = s_r.dtc_id;
  assign nmi_o = s_r.nmi;
  assign wake_o = s_r.wake;
endmodule : icu_top
`default_nettype wire

// ### verification/icu_assertions.sv
// Checker of the interrupt controller top ports.
// Assumes one clock domain; bound to every icu_top instance.
`timescale 1ns/1ps
`default_nettype none
module icu_chk
  import icu_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic osc_stop_i,
  input wire logic wdt_underflow_i,
  input wire logic wdt_refresh_err_i,
  input wire logic vmon_one_i,
  input wire logic vmon_two_i,
  input wire logic irq_req_o,
  input wire logic cpu_ack_i,
  input wire logic dtc_req_o,
  input wire logic dtc_ack_i,
  input wire logic nmi_o
);
  // ==========================================
  // Properties
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);
  sequence s_nmi_kept;
    nmi_o && !(wr_i && addr_i == OFS_NMI_STAT);
  endsequence
  property p_osc;
    $rose(osc_stop_i) |=> nmi_o;
  endproperty
  property p_wdt;
    $rose(wdt_underflow_i) || $rose(wdt_refresh_err_i) |=> nmi_o;
  endproperty
  property p_vmon;
    $rose(vmon_one_i) || $rose(vmon_two_i) |=> nmi_o;
  endproperty
  // Mask is registered on the same edge as nmi_o, so no overlap cycle is legal
  property p_mask;
    nmi_o |-> !irq_req_o;
  endproperty
  property p_nmi_hold;
    s_nmi_kept |=> nmi_o;
  endproperty
  property p_irq_hold;
    irq_req_o && !cpu_ack_i && !dtc_ack_i && !wr_i |=> irq_req_o || nmi_o;
  endproperty
  property p_dtc_hold;
    dtc_req_o && !dtc_ack_i && !cpu_ack_i && !wr_i |=> dtc_req_o;
  endproperty
  property p_rd_idle;
    !rd_i |=> rdata_o == '0;
  endproperty
  a_osc: assert property (p_osc)
    else $error("no nmi after oscillator stop");
  a_wdt: assert property (p_wdt)
    else $error("no nmi after watchdog event");
  a_vmon: assert property (p_vmon)
    else $error("no nmi after voltage monitor event");
  a_mask: assert property (p_mask)
    else $error("maskable request shown during nmi");
  a_nmi_hold: assert property (p_nmi_hold)
    else $error("nmi dropped without clear");
  a_irq_hold: assert property (p_irq_hold)
    else $error("cpu request dropped without accept");
  a_dtc_hold: assert property (p_dtc_hold)
    else $error("transfer request dropped without accept");
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");
endmodule : icu_chk
bind icu_top icu_chk i_icu_chk (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .osc_stop_i(osc_stop_i), .wdt_underflow_i(wdt_underflow_i),
  .wdt_refresh_err_i(wdt_refresh_err_i), .vmon_one_i(vmon_one_i), .vmon_two_i(vmon_two_i),
  .irq_req_o(irq_req_o), .cpu_ack_i(cpu_ack_i), .dtc_req_o(dtc_req_o), .dtc_ack_i(dtc_ack_i),
  .nmi_o(nmi_o)
);
`default_nettype wire

// ### verification/icu_host_model.sv
// Behavioural CPU core and transfer controller accepting requests.
// Assumes requests are registered levels from the controller.
`timescale 1ns/1ps
`default_nettype none
module icu_host_model (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic en_i,
  input wire logic [1:0] lat_i,
  input wire logic irq_req_i,
  input wire logic dtc_req_i,
  output logic cpu_ack_o,
  output logic dtc_ack_o
);
  // ==========================================
  // Accept after lat_i cycles; never accepts an absent request
  logic [1:0] req;
  logic [1:0] ack;
  logic [1:0][1:0] cnt;
  assign req = {dtc_req_i, irq_req_i};
  assign {dtc_ack_o, cpu_ack_o} = ack;
  always_ff @(posedge ref_clk_i) begin
    for (int k = 0; k < 2; k++) begin
      if (reset_i || !req[k]) begin
        ack[k] <= 1'b0;
        cnt[k] <= 2'h0;
      end else if (en_i && !ack[k] && cnt[k] >= lat_i) begin
        ack[k] <= 1'b1;
        cnt[k] <= 2'h0;
      end else begin
        ack[k] <= 1'b0;
        cnt[k] <= (cnt[k] == 2'h3) ? cnt[k] : cnt[k] + 2'h1;
      end
    end
  end
endmodule : icu_host_model
`default_nettype wire

// ### verification/icu_tb_top.sv
// Self-checking bench of the interrupt controller with a host model.
// Assumes default design parameters: 8 peripherals, 8 pins, event link present.
`timescale 1ns/1ps
`default_nettype none
module icu_tb_top import icu_pkg::*;;
  logic ref_clk_i = 1'b0;
  logic reset_i, wr_i, rd_i, ev_a, ev_b, nmi_pin, cpu_ack, dtc_ack, p_en;
  logic irq_req, irq_fast, dtc_req, nmi, wake;
  logic [7:0] addr_i, periph, pins;
  logic [31:0] wdata_i, rdata;
  logic [4:0] nmi_c, irq_id, dtc_id;
  logic [3:0] irq_lvl;
  logic [1:0] p_lat;
  int n_mismatch = 0;
  int checked = 0;
  always #10 ref_clk_i = ~ref_clk_i;
  icu_top i_icu_top (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .periph_req_i(periph), .ext_req_pin_i(pins),
    .event_link_irq_a_i(ev_a), .event_link_irq_b_i(ev_b), .nmi_pin_i(nmi_pin), .osc_stop_i(nmi_c[0]),
    .wdt_underflow_i(nmi_c[1]), .wdt_refresh_err_i(nmi_c[2]), .vmon_one_i(nmi_c[3]), .vmon_two_i(nmi_c[4]),
    .irq_req_o(irq_req), .irq_id_o(irq_id), .irq_lvl_o(irq_lvl), .irq_fast_o(irq_fast), .cpu_ack_i(cpu_ack),
    .dtc_req_o(dtc_req), .dtc_id_o(dtc_id), .dtc_ack_i(dtc_ack), .nmi_o(nmi), .wake_o(wake));
  icu_host_model i_icu_host_model (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .en_i(p_en), .lat_i(p_lat),
    .irq_req_i(irq_req), .dtc_req_i(dtc_req), .cpu_ack_o(cpu_ack), .dtc_ack_o(dtc_ack));
  // ==========================================
  // Helpers
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : wt
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 chk(s, e, rdata & m);
  endtask : rdc
  // Bounded wait for the host model to accept
  task automatic wack(input bit d);
    int i;
    for (i = 0; i < 40; i++) begin
      @(posedge ref_clk_i);
      #1;
      if (d ? dtc_ack : cpu_ack) break;
    end
    if (i == 40) chk("ack", 1, 0);
  endtask : wack
  task automatic pcfg(input logic [2:0] v);
    for (int i = 0; i < 8; i++) wr(OFS_PIN_CFG + 8'(4 * i), {29'h0, v});
  endtask : pcfg
  function automatic int win(input int p[8], input logic [7:0] m);
    int w = -1;
    for (int i = 0; i < 8; i++) if (m[i] && (w < 0 || p[i] > p[w])) w = i;
    return w;
  endfunction : win
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  // ==========================================
  // Tests
  initial begin
    int pr[8];
    int f;
    int w;
    logic [7:0] left;
    reset_i = 1'b1; wr_i = 1'b0; rd_i = 1'b0; addr_i = 8'h00; wdata_i = 32'h0; periph = 8'h00;
    pins = 8'hff; ev_a = 1'b0; ev_b = 1'b0; nmi_pin = 1'b1; nmi_c = 5'h00; p_en = 1'b0; p_lat = 2'h0;
    void'($urandom(32'h13811613));
    wt(4);
    reset_i <= 1'b0;
    rdc(OFS_CPU_EN, '1, 32'h0, "cpu_en");
    rdc(OFS_PRIO, '1, 32'h0, "prio0");
    wr(OFS_PRIO + 8'h04, '1);
    rdc(OFS_PRIO + 8'h04, '1, 32'hf, "prio1");
    wr(8'hfc, '1);
    rdc(8'hfc, '1, 32'h0, "unmapped");
    rdc(8'h41, '1, 32'h0, "misaligned");
    $display("test regs done");
    for (int i = 0; i < 8; i++) begin
      pr[i] = $urandom_range(15, 1);
      wr(OFS_PRIO + 8'(4 * i), 32'(pr[i]));
    end
    // Force a tie so the index order is exercised
    pr[6] = pr[2];
    wr(OFS_PRIO + 8'h18, 32'(pr[6]));
    f = $urandom_range(7, 0);
    wr(OFS_FAST_SEL, 32'h80 | 32'((f + 1) % 8));
    wr(OFS_FAST_SEL, 32'h80 | 32'(f));
    wr(OFS_CPU_EN, 32'hff);
    periph <= 8'hff;
    @(posedge ref_clk_i) periph <= 8'h00;
    p_lat <= 2'($urandom);
    p_en <= 1'b1;
    left = 8'hff;
    repeat (8) begin
      wack(0);
      w = win(pr, left);
      chk("irq_id", 32'(w), {27'h0, irq_id});
      chk("irq_lvl", 32'(pr[w]), {28'h0, irq_lvl});
      chk("irq_fast", 32'(w == f), {31'h0, irq_fast});
      left[w] = 1'b0;
    end
    p_en <= 1'b0;
    rdc(OFS_PEND, 32'hff, 32'h0, "pend_drained");
    $display("test arbitration done");
    for (int m = 0; m < 4; m++) begin
      pcfg({1'($urandom), 2'(m)});
      wt(8);
      wr(OFS_PEND, 32'hff00);
      pins <= 8'h00;
      wt(8);
      rdc(OFS_PEND, 32'hff00, (m != 2) ? 32'hff00 : 32'h0, "pin_fall");
      wr(OFS_PEND, 32'hff00);
      pins <= 8'hff;
      wt(8);
      if (m != 0) rdc(OFS_PEND, 32'hff00, (m >= 2) ? 32'hff00 : 32'h0, "pin_rise");
    end
    pcfg(3'b101);
    wt(8);
    wr(OFS_PEND, 32'hff00);
    pins <= 8'h00;
    @(posedge ref_clk_i) pins <= 8'hff;
    wt(8);
    rdc(OFS_PEND, 32'hff00, 32'h0, "pin_glitch");
    $display("test pins done");
    for (int i = 16; i < 19; i++) wr(OFS_PRIO + 8'(4 * i), 32'h1);
    wr(OFS_DTC_SEL, 32'h70000);
    p_lat <= 2'h2;
    p_en <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      if (k == 0) wr(OFS_SW_TRIG, 32'h1);
      else begin
        @(posedge ref_clk_i);
        ev_a <= (k == 1);
        ev_b <= (k == 2);
        @(posedge ref_clk_i);
        ev_a <= 1'b0;
        ev_b <= 1'b0;
      end
      wack(1);
      chk("dtc_id", 32'(16 + k), {27'h0, dtc_id});
      chk("dtc_req", 32'h1, {31'h0, dtc_req});
    end
    p_en <= 1'b0;
    $display("test transfer done");
    periph <= 8'h01;
    @(posedge ref_clk_i) periph <= 8'h00;
    wt(3);
    #1 chk("irq_on", 32'h1, {31'h0, irq_req});
    for (int b = 0; b < 6; b++) begin
      if (b == 0) nmi_pin <= 1'b0;
      else begin
        @(posedge ref_clk_i) nmi_c <= 5'(1 << (b - 1));
        @(posedge ref_clk_i) nmi_c <= 5'h00;
      end
      wt(4);
      rdc(OFS_NMI_STAT, 32'h3f, 32'(1 << b), "nmi_stat");
      chk("nmi_o", 32'h1, {31'h0, nmi});
      chk("irq_masked", 32'h0, {31'h0, irq_req});
      wr(OFS_NMI_STAT, 32'h3f);
    end
    wr(OFS_NMI_CFG, 32'h1);
    nmi_pin <= 1'b1;
    wt(4);
    rdc(OFS_NMI_STAT, 32'h3f, 32'h1, "nmi_rise");
    wr(OFS_NMI_STAT, 32'h3f);
    wt(2);
    #1 chk("irq_back", 32'h1, {31'h0, irq_req});
    // Rising mode with filter: a one-sample low pulse must not make an edge
    wr(OFS_NMI_CFG, 32'h3);
    nmi_pin <= 1'b0;
    @(posedge ref_clk_i) nmi_pin <= 1'b1;
    wt(4);
    rdc(OFS_NMI_STAT, 32'h3f, 32'h0, "nmi_glitch");
    $display("test nmi done");
    pcfg(3'b010);
    wr(OFS_PEND, 32'hff00);
    wr(OFS_PWR_MODE, {30'h0, PWR_STBY});
    wt(2);
    #1 chk("wake_stby", 32'h0, {31'h0, wake});
    wr(OFS_PWR_MODE, {30'h0, PWR_SLEEP});
    wt(2);
    #1 chk("wake_sleep", 32'h1, {31'h0, wake});
    wr(OFS_PWR_MODE, {30'h0, PWR_DEEP});
    wt(2);
    #1 chk("wake_deep", 32'h1, {31'h0, wake});
    wr(OFS_PWR_MODE, {30'h0, PWR_STBY});
    wr(OFS_PIN_CFG, 32'h0);
    pins <= 8'hfe;
    wt(5);
    #1 chk("wake_pin", 32'h1, {31'h0, wake});
    wr(OFS_PWR_MODE, {30'h0, PWR_RUN});
    wt(2);
    #1 chk("wake_run", 32'h0, {31'h0, wake});
    pins <= 8'hff;
    $display("test wake done");
    test_done;
  end
  // Whole run needs a few hundred cycles; far beyond that means a hang
  initial begin
    wt(20000);
    n_mismatch++;
    test_done;
  end
endmodule : icu_tb_top
`default_nettype wire
